// >>> rtl/tmc_mode_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - config-select low forces configuration mode at once, from any state.
// - other modes chosen from config-select, transceiver enable and mode bit.
// - exactly one of configuration, transmit, receive, standby is active.
// - after reset the controller sits in standby with reset values.
// - the mode machine steps only on digital clock ticks, except the configuration force.
// - oscillator and manager off: receiver off while wake is low, on while wake is high.
// - serial-enable high tri-states clock, mosi, miso and ignores the bus.
// - serial-enable high keeps state but forces the power amplifier off.
// - one byte moves in eight serial clocks, clock from the master.
// - mosi is input in configuration and transmit, output in receive.
// - bytes shift most significant bit first in both directions.
// - with nothing to send, clock and mosi are driven low.
// - miso carries read data only in configuration, valid on falling edges.
// - in transmit mode mosi is a plain input of encoded host data.
// - receive with data manager on: device is master on clock and mosi.
// - in standby the port is deselected and all outputs tri-stated.
// - wake already high on receive entry goes straight to receiver on.
// - data manager off: raw bits stream on mosi, clock held low.
// - manager and oscillator off: idle standby, wake high turns receiver on.
// - oscillator on: off state counts; wake driven high freezes the count.
// - receiver turns on from off on wake high or off count match.
// - the digital clock is divided down from the crystal clock.
module tmc_mode_ctrl
(
    // clock and reset
    input  logic       clk_sys_i,
    input  logic       nrst_i,
    // host control pins
    input  logic       config_select_n_i,
    input  logic       wake_i,
    input  logic       wake_driven_i,
    input  logic       serial_enable_n_i,
    // configuration bits
    input  logic       transceiver_enable_i,
    input  logic       mode_tx_i,
    input  logic       data_manager_enable_i,
    input  logic       strobe_osc_enable_i,
    input  logic [7:0] off_time_count_i,
    input  logic       crystal_band_select_i,
    // receiver side
    input  logic       strobe_osc_tick_i,
    input  logic       raw_data_i,
    input  logic [7:0] dm_byte_i,
    input  logic       dm_valid_i,
    output logic       dm_ready_o,
    // configuration byte side
    input  logic [7:0] cfg_rd_byte_i,
    output logic [7:0] cfg_byte_o,
    output logic       cfg_byte_valid_o,
    // serial pins
    input  logic       sclk_i,
    output logic       sclk_o,
    output logic       sclk_oe_n_o,
    input  logic       mosi_i,
    output logic       mosi_o,
    output logic       mosi_oe_n_o,
    output logic       miso_o,
    output logic       miso_oe_n_o,
    // status
    output logic [1:0] mode_o,
    output logic [2:0] rx_state_o,
    output logic       rx_on_o,
    output logic       pa_enable_o,
    output logic       tx_data_o
);

    // =====================================================================
    // state
    typedef struct packed
    {
        tmc_pkg::tmc_mode_e mode;
        tmc_pkg::tmc_rx_e   rx;
        logic [7:0]         off_cnt;
        logic [7:0]         on_cnt;
        logic               osc_pend;
        logic [7:0]         shreg;
        logic [2:0]         bitcnt;
        logic               busy;
        logic               sclk;
        logic               mosi;
        logic               pa_on;
        logic               tx_data;
    } tmc_ctrl_s;

    tmc_ctrl_s st;
    tmc_ctrl_s next_st;
    logic      tick;
    logic      slave_en;
    logic      cfg_miso;

    // =====================================================================
    // mode choice outside configuration
    function automatic tmc_pkg::tmc_mode_e pick_mode(input logic transceiver_enable, input logic txm);
        if (!transceiver_enable)
            pick_mode = tmc_pkg::TMC_STBY;
        else if (txm)
            pick_mode = tmc_pkg::TMC_TX;
        else
            pick_mode = tmc_pkg::TMC_RX;
    endfunction

    // receive sub-state on entry
    function automatic tmc_pkg::tmc_rx_e pick_rx(input logic data_manager_enable, input logic strobe_osc_enable,
                                                 input logic wk);
        if (data_manager_enable)
            pick_rx = tmc_pkg::RX_DM_ON;
        else if (wk)
            pick_rx = tmc_pkg::RX_PIN_ON;
        else if (strobe_osc_enable)
            pick_rx = tmc_pkg::RX_OFF;
        else
            pick_rx = tmc_pkg::RX_STBY;
    endfunction

    // =====================================================================
    // digital clock and configuration slave
    tmc_digclk_div u_div
    (
        .clk_sys_i             (clk_sys_i),
        .nrst_i                (nrst_i),
        .crystal_band_select_i (crystal_band_select_i),
        .tick_o                (tick)
    );

    assign slave_en = (st.mode == tmc_pkg::TMC_CFG) && !serial_enable_n_i;

    tmc_cfg_slave u_slv
    (
        .clk_sys_i  (clk_sys_i),
        .nrst_i     (nrst_i),
        .enable_i   (slave_en),
        .sclk_i     (sclk_i),
        .mosi_i     (mosi_i),
        .miso_o     (cfg_miso),
        .rd_byte_i  (cfg_rd_byte_i),
        .wr_byte_o  (cfg_byte_o),
        .wr_valid_o (cfg_byte_valid_o)
    );

    // =====================================================================
    // next state
    always_comb
    begin
        next_st = st;
        // strobe ticks held until the next digital tick, set wins
        next_st.osc_pend = st.osc_pend || strobe_osc_tick_i;
        if (!config_select_n_i)
        begin
            next_st.mode = tmc_pkg::TMC_CFG;
            next_st.busy = 1'b0;
            next_st.sclk = 1'b0;
            next_st.mosi = 1'b0;
        end
        else if (tick)
        begin
            next_st.osc_pend = strobe_osc_tick_i;
            if (pick_mode(transceiver_enable_i, mode_tx_i) != st.mode)
            begin
                next_st.mode    = pick_mode(transceiver_enable_i, mode_tx_i);
                next_st.rx      = pick_rx(data_manager_enable_i, strobe_osc_enable_i,
                                          wake_i);
                next_st.off_cnt = tmc_pkg::CNT_RESET;
                next_st.on_cnt  = tmc_pkg::CNT_RESET;
                next_st.busy    = 1'b0;
                next_st.sclk    = 1'b0;
                next_st.mosi    = 1'b0;
            end
            else if (st.mode == tmc_pkg::TMC_RX)
            begin
                case (st.rx)
                    tmc_pkg::RX_STBY:
                    begin
                        if (wake_i)
                            next_st.rx = tmc_pkg::RX_PIN_ON;
                    end
                    tmc_pkg::RX_PIN_ON:
                    begin
                        if (!wake_i)
                            next_st.rx = strobe_osc_enable_i ? tmc_pkg::RX_OFF
                                                             : tmc_pkg::RX_STBY;
                    end
                    tmc_pkg::RX_OFF:
                    begin
                        if (wake_driven_i && wake_i)
                        begin
                            next_st.rx      = tmc_pkg::RX_OSC_ON;
                            next_st.off_cnt = tmc_pkg::CNT_RESET;
                        end
                        else if (st.off_cnt == off_time_count_i && !wake_driven_i)
                        begin
                            next_st.rx      = tmc_pkg::RX_OSC_ON;
                            next_st.off_cnt = tmc_pkg::CNT_RESET;
                        end
                        else if (st.osc_pend && !wake_driven_i)
                            next_st.off_cnt = st.off_cnt + 8'h01;
                    end
                    tmc_pkg::RX_OSC_ON:
                    begin
                        if ((wake_driven_i && !wake_i) ||
                            (!wake_driven_i && st.on_cnt == tmc_pkg::ON_TICKS))
                        begin
                            next_st.rx     = tmc_pkg::RX_OFF;
                            next_st.on_cnt = tmc_pkg::CNT_RESET;
                        end
                        else if (st.osc_pend && !wake_driven_i)
                            next_st.on_cnt = st.on_cnt + 8'h01;
                    end
                    tmc_pkg::RX_DM_ON:
                    begin
                        // master byte engine
                        if (st.busy)
                        begin
                            next_st.sclk = !st.sclk;
                            if (!st.sclk)
                                next_st.mosi = st.shreg[7];
                            else
                            begin
                                next_st.shreg  = {st.shreg[6:0], 1'b0};
                                next_st.bitcnt = st.bitcnt + 3'h1;
                                if (st.bitcnt == tmc_pkg::BIT_LAST)
                                    next_st.busy = 1'b0;
                            end
                        end
                        else
                        begin
                            next_st.sclk = 1'b0;
                            next_st.mosi = 1'b0;
                        end
                    end
                    default:
                    begin
                        next_st.rx = tmc_pkg::RX_STBY;
                    end
                endcase
            end
        end
        // byte load from the data manager
        if (dm_ready_o && dm_valid_i)
        begin
            next_st.shreg  = dm_byte_i;
            next_st.bitcnt = tmc_pkg::BIT_ZERO;
            next_st.busy   = 1'b1;
        end
        // raw stream with clock held low
        if (st.mode == tmc_pkg::TMC_RX && st.rx != tmc_pkg::RX_DM_ON)
        begin
            next_st.sclk = 1'b0;
            next_st.mosi = (st.rx == tmc_pkg::RX_PIN_ON || st.rx == tmc_pkg::RX_OSC_ON)
                           ? raw_data_i : 1'b0;
        end
        // power amplifier gated by serial enable
        next_st.pa_on   = (next_st.mode == tmc_pkg::TMC_TX) && !serial_enable_n_i;
        // transmit data taken from mosi as a plain input
        next_st.tx_data = (st.mode == tmc_pkg::TMC_TX && !serial_enable_n_i) ? mosi_i : 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            st      <= '0;
            st.mode <= tmc_pkg::TMC_STBY;
            st.rx   <= tmc_pkg::RX_STBY;
        end
        else
            st <= next_st;
    end

    // =====================================================================
    // pins and status
    assign dm_ready_o  = (st.mode == tmc_pkg::TMC_RX) && (st.rx == tmc_pkg::RX_DM_ON) &&
                         !st.busy && config_select_n_i;
    // tri-state per mode
    assign sclk_oe_n_o = serial_enable_n_i || (st.mode != tmc_pkg::TMC_RX);
    assign mosi_oe_n_o = serial_enable_n_i || (st.mode != tmc_pkg::TMC_RX);
    assign miso_oe_n_o = serial_enable_n_i || (st.mode != tmc_pkg::TMC_CFG);
    assign sclk_o      = st.sclk;
    assign mosi_o      = st.mosi;
    assign miso_o      = cfg_miso;
    assign mode_o      = st.mode;
    assign rx_state_o  = st.rx;
    assign rx_on_o     = (st.mode == tmc_pkg::TMC_RX) && (st.rx != tmc_pkg::RX_STBY) &&
                         (st.rx != tmc_pkg::RX_OFF);
    assign pa_enable_o = st.pa_on;
    assign tx_data_o   = st.tx_data;

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    a_cfg_force_entry: assert property (!config_select_n_i |=>
                                        mode_o == tmc_pkg::TMC_CFG)
        else $error("config select low did not force configuration");
    a_mode_on_tick: assert property ($changed(st.mode) |-> $past(tick) ||
                                     !$past(config_select_n_i) || !$past(nrst_i))
        else $error("mode changed off the digital tick");
    a_tx_select_mode: assert property (config_select_n_i && tick && transceiver_enable_i &&
                                       mode_tx_i |=> mode_o == tmc_pkg::TMC_TX)
        else $error("transmit not selected");
    a_stby_select_mode: assert property (config_select_n_i && tick && !transceiver_enable_i
                                         |=> mode_o == tmc_pkg::TMC_STBY)
        else $error("standby not selected");
    a_reset_standby: assert property (@(posedge clk_sys_i) disable iff (1'b0)
                                      !nrst_i |=> st.mode == tmc_pkg::TMC_STBY)
        else $error("reset did not leave standby");
    a_pa_sen_off: assert property (serial_enable_n_i |=> !pa_enable_o)
        else $error("amplifier on with serial enable high");
    a_pins_sen_hiz: assert property (serial_enable_n_i |-> sclk_oe_n_o && mosi_oe_n_o &&
                                     miso_oe_n_o)
        else $error("pin driven with serial enable high");
    a_stby_pins_hiz: assert property (mode_o == tmc_pkg::TMC_STBY |-> sclk_oe_n_o &&
                                      mosi_oe_n_o && miso_oe_n_o)
        else $error("pin driven in standby");
    a_rx_wake_on: assert property (st.mode == tmc_pkg::TMC_RX && st.rx == tmc_pkg::RX_STBY &&
                                   wake_i && tick && config_select_n_i && transceiver_enable_i &&
                                   !mode_tx_i |=> rx_on_o)
        else $error("wake high did not turn receiver on");
    a_off_count_on: assert property (st.mode == tmc_pkg::TMC_RX && st.rx == tmc_pkg::RX_OFF &&
                                     !wake_driven_i && st.off_cnt == off_time_count_i && tick &&
                                     config_select_n_i && transceiver_enable_i && !mode_tx_i
                                     |=> st.rx == tmc_pkg::RX_OSC_ON)
        else $error("off count match did not wake receiver");
    a_raw_sclk_low: assert property (st.mode == tmc_pkg::TMC_RX && st.rx != tmc_pkg::RX_DM_ON
                                     ##1 st.mode == tmc_pkg::TMC_RX |-> !sclk_o)
        else $error("clock not low in raw receive");
    a_byte_eight_bits: assert property ($fell(st.busy) && st.mode == tmc_pkg::TMC_RX
                                        |-> $past(st.bitcnt) == tmc_pkg::BIT_LAST)
        else $error("byte did not take eight clocks");

    c_cfg_entry: cover property ($rose(mode_o == tmc_pkg::TMC_CFG));
    c_tx_entry: cover property ($rose(pa_enable_o));
    c_osc_wake: cover property (st.rx == tmc_pkg::RX_OFF ##1 st.rx == tmc_pkg::RX_OSC_ON);
    c_dm_byte: cover property ($fell(st.busy));

endmodule

// >>> common/tmc_pkg.sv
package tmc_pkg;

    // =====================================================================
    // digital clock divider, selected by crystal band bit 0
    localparam logic [5:0] DIG_DIV_MAX_LO = 6'h1D;
    localparam logic [5:0] DIG_DIV_MAX_HI = 6'h27;

    // =====================================================================
    // serial byte framing
    localparam int unsigned BYTE_W   = 8;
    localparam logic [2:0]  BIT_LAST = 3'h7;
    localparam logic [2:0]  BIT_ZERO = 3'h0;

    // =====================================================================
    // strobe timing and reset values
    localparam int unsigned OFF_W      = 8;
    localparam logic [7:0]  ON_TICKS   = 8'h04;
    localparam logic [7:0]  CNT_RESET  = 8'h00;
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [5:0]  DIV_RESET  = 6'h00;

    // =====================================================================
    // modes and receive sub-states
    typedef enum logic [1:0] {TMC_CFG, TMC_TX, TMC_RX, TMC_STBY} tmc_mode_e;
    typedef enum logic [2:0] {RX_STBY, RX_PIN_ON, RX_OFF, RX_OSC_ON, RX_DM_ON} tmc_rx_e;

endpackage

// >>> rtl/tmc_digclk_div.sv
`timescale 1ns/10ps
module tmc_digclk_div
(
    // clock and reset
    input  logic clk_sys_i,
    input  logic nrst_i,
    // band select
    input  logic crystal_band_select_i,
    // divided tick
    output logic tick_o
);

    // =====================================================================
    // state
    typedef struct packed
    {
        logic [5:0] cnt;
        logic       tick;
    } tmc_div_s;

    tmc_div_s st;
    tmc_div_s next_st;
    logic [5:0] lim;

    // =====================================================================
    // divide crystal clock down to the digital clock
    always_comb
    begin
        lim = crystal_band_select_i ? tmc_pkg::DIG_DIV_MAX_HI : tmc_pkg::DIG_DIV_MAX_LO;
        next_st = st;
        next_st.tick = (st.cnt == lim);
        next_st.cnt  = (st.cnt == lim) ? tmc_pkg::DIV_RESET : st.cnt + 6'h01;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick_o = st.tick;

endmodule

// >>> rtl/tmc_cfg_slave.sv
`timescale 1ns/10ps
module tmc_cfg_slave
(
    // clock and reset
    input  logic       clk_sys_i,
    input  logic       nrst_i,
    // control
    input  logic       enable_i,
    // serial lines
    input  logic       sclk_i,
    input  logic       mosi_i,
    output logic       miso_o,
    // byte side
    input  logic [7:0] rd_byte_i,
    output logic [7:0] wr_byte_o,
    output logic       wr_valid_o
);

    // =====================================================================
    // state
    typedef struct packed
    {
        logic       sclk_q;
        logic [2:0] cnt;
        logic [7:0] txsh;
        logic [7:0] rxsh;
        logic       miso;
        logic [7:0] wr_byte;
        logic       wr_valid;
    } tmc_slv_s;

    tmc_slv_s st;
    tmc_slv_s next_st;
    logic [7:0] src;

    // =====================================================================
    // msb first, drive on rising edge, sample on falling edge
    always_comb
    begin
        next_st = st;
        next_st.sclk_q = sclk_i;
        next_st.wr_valid = 1'b0;
        src = (st.cnt == tmc_pkg::BIT_ZERO) ? rd_byte_i : st.txsh;
        if (!enable_i)
        begin
            next_st.cnt = tmc_pkg::BIT_ZERO;
        end
        else if (sclk_i && !st.sclk_q)
        begin
            next_st.miso = src[7];
            next_st.txsh = {src[6:0], 1'b0};
        end
        else if (!sclk_i && st.sclk_q)
        begin
            // one byte per eight clocks
            next_st.rxsh = {st.rxsh[6:0], mosi_i};
            next_st.cnt  = st.cnt + 3'h1;
            if (st.cnt == tmc_pkg::BIT_LAST)
            begin
                next_st.wr_byte  = {st.rxsh[6:0], mosi_i};
                next_st.wr_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign miso_o     = st.miso;
    assign wr_byte_o  = st.wr_byte;
    assign wr_valid_o = st.wr_valid;

endmodule

// >>> dv/tmc_host_model.sv
`timescale 1ns/10ps
// ======================================================================
// host spi master, clock idle low, data valid on falling clock
module tmc_host_model
(
    // clock
    input  logic       clk_i,
    // request
    input  logic       start_i,
    input  logic [7:0] byte_i,
    output logic [7:0] byte_o,
    output logic       done_o,
    // serial lines
    input  logic       miso_i,
    output logic       sclk_o,
    output logic       mosi_o
);
    int i;
    initial
    begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        done_o = 1'b0;
        byte_o = 8'h00;
    end
    always @(posedge clk_i)
    begin
        if (start_i)
        begin
            done_o <= 1'b0;
            for (i = 7; i >= 0; i--)
            begin
                sclk_o <= 1'b1;
                mosi_o <= byte_i[i];
                repeat (4) @(posedge clk_i);
                byte_o[i] <= miso_i;
                sclk_o <= 1'b0;
                repeat (4) @(posedge clk_i);
            end
            mosi_o <= ~mosi_o;
            done_o <= 1'b1;
        end
    end
endmodule

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
    logic       clk_sys_i = 1'b0, nrst_i = 1'b0, config_select_n_i = 1'b1, wake_i = 1'b0;
    logic       wake_driven_i = 1'b1, serial_enable_n_i = 1'b0, transceiver_enable_i = 1'b0;
    logic       mode_tx_i = 1'b0, data_manager_enable_i = 1'b0, strobe_osc_enable_i = 1'b0;
    logic       crystal_band_select_i = 1'b0, strobe_osc_tick_i = 1'b0, raw_data_i = 1'b0;
    logic       dm_valid_i = 1'b0, use_tb = 1'b0, tb_mosi = 1'b0, start = 1'b0;
    logic [7:0] off_time_count_i = 8'h02, dm_byte_i = 8'h00, cfg_rd_byte_i = 8'h00;
    logic [7:0] h_byte, cfg_byte_o, b, got;
    logic [15:0] rnd;
    logic [2:0] rx_state_o;
    logic [1:0] mode_o;
    logic       dm_ready_o, cfg_byte_valid_o, sclk_i, sclk_o, sclk_oe_n_o, mosi_i, mosi_o;
    logic       mosi_oe_n_o, miso_o, miso_oe_n_o, rx_on_o, pa_enable_o, tx_data_o;
    logic       h_sclk, h_mosi, done, prev;
    int         n_errors = 0, checks_done = 0, cyc = 0, nval = 0, k, n;
    always #2.5 clk_sys_i = ~clk_sys_i;
    assign sclk_i = sclk_oe_n_o ? h_sclk : sclk_o;
    assign mosi_i = !mosi_oe_n_o ? mosi_o : (use_tb ? tb_mosi : h_mosi);
    tmc_mode_ctrl DUT (.clk_sys_i, .nrst_i, .config_select_n_i, .wake_i, .wake_driven_i,
        .serial_enable_n_i, .transceiver_enable_i, .mode_tx_i, .data_manager_enable_i,
        .strobe_osc_enable_i, .off_time_count_i, .crystal_band_select_i, .strobe_osc_tick_i,
        .raw_data_i, .dm_byte_i, .dm_valid_i, .dm_ready_o, .cfg_rd_byte_i, .cfg_byte_o,
        .cfg_byte_valid_o, .sclk_i, .sclk_o, .sclk_oe_n_o, .mosi_i, .mosi_o, .mosi_oe_n_o,
        .miso_o, .miso_oe_n_o, .mode_o, .rx_state_o, .rx_on_o, .pa_enable_o, .tx_data_o);
    tmc_host_model host (.clk_i(clk_sys_i), .start_i(start), .byte_i(b), .byte_o(h_byte),
        .done_o(done), .miso_i(miso_o), .sclk_o(h_sclk), .mosi_o(h_mosi));
    // ======================================================================
    // helpers
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task tk(input int c);
        repeat (c) @(posedge clk_sys_i);
    endtask
    task wt(input bit rx, input logic [7:0] e);
        for (k = 0; k < 100 && (rx ? {5'h00, rx_state_o} : {6'h00, mode_o}) !== e; k++)
        begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(rx ? "rx_state" : "mode", rx ? {5'h00, rx_state_o} : {6'h00, mode_o}, e);
    endtask
    task enter_cfg;
        @(posedge clk_sys_i);
        config_select_n_i <= 1'b0;
        tk(1);
        @(posedge clk_sys_i);
        #1;
        chk("cfg_entry", {6'h00, mode_o}, {6'h00, tmc_pkg::TMC_CFG});
    endtask
    task leave(input logic en, input logic tx, input logic [1:0] m);
        @(posedge clk_sys_i);
        config_select_n_i <= 1'b1;
        transceiver_enable_i <= en;
        mode_tx_i <= tx;
        wt(0, {6'h00, m});
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        nval += cfg_byte_valid_o;
        if (cyc == 30000)
        begin
            n_errors++;
            summarize();
        end
    end
    // ======================================================================
    // main sequence
    initial
    begin
        rnd = 16'hAD09;
        tk(4);
        nrst_i <= 1'b1;
        crystal_band_select_i <= rnd[0];
        #1;
        chk("rst_mode", {6'h00, mode_o}, {6'h00, tmc_pkg::TMC_STBY});
        chk("rst_oe", {5'h00, sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 8'h07);
        wake_i <= 1'b1;
        enter_cfg();
        chk("miso_oe", {7'h00, miso_oe_n_o}, 8'h00);
        repeat (4)
        begin
            rnd = nx(rnd);
            cfg_rd_byte_i <= rnd[15:8];
            b = rnd[7:0];
            @(posedge clk_sys_i);
            start <= 1'b1;
            @(posedge clk_sys_i);
            start <= 1'b0;
            #1;
            for (k = 0; k < 200 && done !== 1'b1; k++)
                @(posedge clk_sys_i);
            tk(2);
            chk("cfg_byte", cfg_byte_o, b);
            chk("miso_byte", h_byte, cfg_rd_byte_i);
        end
        chk("valids", nval[7:0], 8'h04);
        $display("test config done");
        use_tb <= 1'b1;
        leave(1'b1, 1'b1, tmc_pkg::TMC_TX);
        repeat (8)
        begin
            rnd = nx(rnd);
            tb_mosi <= rnd[0];
            @(posedge clk_sys_i);
            #1;
            chk("tx_data", {7'h00, tx_data_o}, {7'h00, tb_mosi});
            chk("tx_pa", {6'h00, pa_enable_o, mosi_oe_n_o}, 8'h03);
        end
        serial_enable_n_i <= 1'b1;
        tk(3);
        chk("sen_pa", {7'h00, pa_enable_o}, 8'h00);
        chk("sen_oe", {5'h00, sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 8'h07);
        chk("sen_mode", {6'h00, mode_o}, {6'h00, tmc_pkg::TMC_TX});
        serial_enable_n_i <= 1'b0;
        use_tb <= 1'b0;
        enter_cfg();
        leave(1'b0, 1'b0, tmc_pkg::TMC_STBY);
        chk("stby_oe", {5'h00, sclk_oe_n_o, mosi_oe_n_o, miso_oe_n_o}, 8'h07);
        $display("test transmit done");
        enter_cfg();
        leave(1'b1, 1'b0, tmc_pkg::TMC_RX);
        wt(1, {5'h00, tmc_pkg::RX_PIN_ON});
        repeat (8)
        begin
            rnd = nx(rnd);
            raw_data_i <= rnd[0];
            @(posedge clk_sys_i);
            @(posedge clk_sys_i);
            #1;
            chk("raw", {5'h00, mosi_o, sclk_o, rx_on_o}, {5'h00, raw_data_i, 2'b01});
            chk("rx_oe", {7'h00, mosi_oe_n_o}, 8'h00);
        end
        wake_i <= 1'b0;
        wt(1, {5'h00, tmc_pkg::RX_STBY});
        chk("rx_off", {7'h00, rx_on_o}, 8'h00);
        wake_i <= 1'b1;
        wt(1, {5'h00, tmc_pkg::RX_PIN_ON});
        $display("test raw receive done");
        wake_i <= 1'b0;
        strobe_osc_enable_i <= 1'b1;
        rnd = nx(rnd);
        off_time_count_i <= {6'h00, rnd[1:0]} + 8'h02;
        enter_cfg();
        leave(1'b1, 1'b0, tmc_pkg::TMC_RX);
        wt(1, {5'h00, tmc_pkg::RX_OFF});
        for (n = 0; n < 20 && rx_state_o !== 3'h3; n++)
        begin
            if (n == 3)
                wake_driven_i <= 1'b0;
            @(posedge clk_sys_i);
            strobe_osc_tick_i <= 1'b1;
            @(posedge clk_sys_i);
            strobe_osc_tick_i <= 1'b0;
            tk(45);
            #1;
            if (n == 2)
                chk("frozen", {5'h00, rx_state_o}, {5'h00, tmc_pkg::RX_OFF});
        end
        chk("off_ticks", {7'h00, n >= off_time_count_i + 3 && n <= off_time_count_i + 5},
            8'h01);
        wake_driven_i <= 1'b1;
        wt(1, {5'h00, tmc_pkg::RX_OFF});
        wake_i <= 1'b1;
        wt(1, {5'h00, tmc_pkg::RX_OSC_ON});
        $display("test strobe done");
        data_manager_enable_i <= 1'b1;
        enter_cfg();
        leave(1'b1, 1'b0, tmc_pkg::TMC_RX);
        wt(1, {5'h00, tmc_pkg::RX_DM_ON});
        chk("dm_ready", {7'h00, dm_ready_o}, 8'h01);
        rnd = nx(rnd);
        dm_byte_i <= rnd[7:0];
        dm_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        for (k = 0; k < 200 && dm_ready_o !== 1'b1; k++)
            @(posedge clk_sys_i);
        dm_valid_i <= 1'b0;
        #1;
        chk("dm_busy", {7'h00, dm_ready_o}, 8'h00);
        prev = 1'b0;
        got = 8'h00;
        for (n = 0, k = 0; k < 1500 && n < 8; k++)
        begin
            @(posedge clk_sys_i);
            #1;
            if (prev && !sclk_o)
            begin
                got = {got[6:0], mosi_o};
                n++;
            end
            prev = sclk_o;
        end
        chk("dm_byte", got, dm_byte_i);
        tk(150);
        #1;
        chk("idle", {6'h00, sclk_o, mosi_o}, 8'h00);
        $display("test manager done");
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        tk(2);
        nrst_i <= 1'b1;
        #1;
        chk("rst2", {3'h0, mode_o, rx_state_o}, {3'h0, tmc_pkg::TMC_STBY, 3'h0});
        $display("test reset done");
        summarize();
    end
endmodule
